// ---- inc/spi_cfg_pkg.sv ----
// shared constants and types for the spi configuration and status block
package spi_cfg_pkg;

  // ****************************************************************
  // widths and types
  // ****************************************************************
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned IRQ_W    = 4;
  localparam int unsigned HALF_W   = 4;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] byte_t;
  typedef logic [IRQ_W-1:0]  irq_t;
  typedef logic [HALF_W-1:0] half_t;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam addr_t CFG_ADDR   = 3'h0;
  localparam addr_t DATA_ADDR  = 3'h1;
  localparam addr_t STAT_ADDR  = 3'h2;
  localparam addr_t MASK_ADDR  = 3'h3;
  localparam addr_t DIV_ADDR   = 3'h4;

  // ****************************************************************
  // configuration and status field positions
  // ****************************************************************
  localparam int unsigned CFG_BUSY_BIT   = 7;
  localparam int unsigned CFG_MASTER_BIT = 6;
  localparam int unsigned CFG_PHASE_BIT  = 5;
  localparam int unsigned CFG_POL_BIT    = 4;
  localparam int unsigned CFG_SEL_BIT    = 3;
  localparam int unsigned CFG_RAW_BIT    = 2;
  localparam int unsigned CFG_SHIFTER_EMPTY_FLAG_BIT   = 1;
  localparam int unsigned CFG_RECEIVE_BUFFER_EMPTY_FLAG_BIT  = 0;

  // ****************************************************************
  // interrupt status field positions
  // ****************************************************************
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_OVR_BIT    = 1;
  localparam int unsigned IRQ_COLL_BIT   = 2;
  localparam int unsigned IRQ_SEL_BIT    = 3;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam byte_t CFG_RST      = 8'h07;
  localparam byte_t BYTE_ZERO    = 8'h00;
  localparam irq_t  IRQ_ZERO     = 4'h0;
  localparam byte_t HALF_DIV_RST = 8'h04;
  localparam byte_t HALF_DIV_MIN = 8'h02;
  localparam byte_t CNT_ONE      = 8'h01;
  localparam half_t HALF_ZERO    = 4'h0;
  localparam half_t HALF_ONE     = 4'h1;
  localparam half_t HALF_LAST    = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

// ---- inc/shift_if.sv ----
// link between the register side and the shift engine
`timescale 1ns/1ps
interface shift_if;
  import spi_cfg_pkg::*;

  logic  master;
  logic  cpol;
  logic  cpha;
  byte_t half_div;
  logic  selected;
  logic  load;
  byte_t tx_data;
  logic  rx_done;
  byte_t rx_data;
  logic  busy;
  logic  mid_byte;
  logic  sck_edge;

  modport ctl (output master, cpol, cpha, half_div, selected, load, tx_data,
               input  rx_done, rx_data, busy, mid_byte, sck_edge);
  modport eng (input  master, cpol, cpha, half_div, selected, load, tx_data,
               output rx_done, rx_data, busy, mid_byte, sck_edge);
endinterface

// ---- hdl/select_filter.sv ----
// synchroniser and glitch filter for the slave select pin
`timescale 1ns/1ps
module select_filter
(
  input  logic clk,
  input  logic nrst,
  input  logic pin_n,
  output logic raw_level,
  output logic selected
);
  import spi_cfg_pkg::*;

  logic s1_q;
  logic s1_d;
  logic s2_q;
  logic s2_d;
  logic s3_q;
  logic s3_d;
  logic stable_q;
  logic stable_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s1_d     = pin_n;
    s2_d     = s1_q;
    s3_d     = s2_q;
    stable_d = stable_q;
    // a new level must be seen on two cycles running
    if (s2_q == s3_q)
    begin
      stable_d = s2_q;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q     <= 1'b1;
      s2_q     <= 1'b1;
      s3_q     <= 1'b1;
      stable_q <= 1'b1;
    end
    else
    begin
      s1_q     <= s1_d;
      s2_q     <= s2_d;
      s3_q     <= s3_d;
      stable_q <= stable_d;
    end
  end

  assign raw_level = s2_q;
  assign selected  = !stable_q;

endmodule // select_filter

// ---- hdl/spi_shifter.sv ----
// shift engine: master clock generation and slave edge tracking
`timescale 1ns/1ps
module spi_shifter
(
  input  logic clk,
  input  logic nrst,
  shift_if.eng sh,
  input  logic sck_in,
  input  logic mosi_in,
  input  logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic miso_out
);
  import spi_cfg_pkg::*;

  logic [2:0] s1_q;
  logic [2:0] s1_d;
  logic [2:0] s2_q;
  logic [2:0] s2_d;
  logic       prev_q;
  logic       prev_d;
  logic       run_q;
  logic       run_d;
  half_t      half_q;
  half_t      half_d;
  half_t      edge_q;
  half_t      edge_d;
  byte_t      cnt_q;
  byte_t      cnt_d;
  byte_t      tx_q;
  byte_t      tx_d;
  byte_t      rx_q;
  byte_t      rx_d;
  byte_t      out_q;
  byte_t      out_d;
  logic       done_q;
  logic       done_d;
  logic       sck_q;
  logic       sck_d;
  logic       slave_edge;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s1_d   = {sck_in, mosi_in, miso_in};
    s2_d   = s1_q;
    prev_d = s2_q[2];
    run_d  = run_q;
    half_d = half_q;
    edge_d = edge_q;
    cnt_d  = cnt_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    out_d  = out_q;
    done_d = 1'b0;
    slave_edge = !sh.master && sh.selected && (s2_q[2] != prev_q);
    if (sh.load)
    begin
      tx_d = sh.tx_data;
      if (sh.master)
      begin
        run_d  = 1'b1;
        half_d = HALF_ZERO;
        cnt_d  = sh.half_div - CNT_ONE;
      end
    end
    else if (sh.master && run_q)
    begin
      // late sample leaves the slave the most settling time
      if (half_q[0] && cnt_q == CNT_ONE)
      begin
        rx_d = {rx_q[DATA_W-2:0], s2_q[0]};
      end
      if (cnt_q == BYTE_ZERO)
      begin
        cnt_d = sh.half_div - CNT_ONE;
        if (half_q == HALF_LAST)
        begin
          run_d  = 1'b0;
          done_d = 1'b1;
          out_d  = rx_q;
        end
        else
        begin
          half_d = half_q + HALF_ONE;
          if (half_q[0])
          begin
            tx_d = {tx_q[DATA_W-2:0], 1'b0};
          end
        end
      end
      else
      begin
        cnt_d = cnt_q - CNT_ONE;
      end
    end
    if (!sh.master && !sh.selected)
    begin
      edge_d = HALF_ZERO;
    end
    else if (slave_edge)
    begin
      edge_d = edge_q + HALF_ONE;
      if (edge_q[0] == sh.cpha)
      begin
        rx_d = {rx_q[DATA_W-2:0], s2_q[1]};
        if (edge_q[3:1] == LAST_BIT)
        begin
          done_d = 1'b1;
          out_d  = {rx_q[DATA_W-2:0], s2_q[1]};
        end
      end
      else if (!(sh.cpha && edge_q == HALF_ZERO))
      begin
        tx_d = {tx_q[DATA_W-2:0], 1'b0};
      end
    end
    // first bit period half is idle level with phase 0, active with phase 1
    sck_d = run_d ? (sh.cpol ^ half_d[0] ^ sh.cpha) : sh.cpol;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q   <= 3'h0;
      s2_q   <= 3'h0;
      prev_q <= 1'b0;
      run_q  <= 1'b0;
      half_q <= HALF_ZERO;
      edge_q <= HALF_ZERO;
      cnt_q  <= BYTE_ZERO;
      tx_q   <= BYTE_ZERO;
      rx_q   <= BYTE_ZERO;
      out_q  <= BYTE_ZERO;
      done_q <= 1'b0;
      sck_q  <= 1'b0;
    end
    else
    begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      prev_q <= prev_d;
      run_q  <= run_d;
      half_q <= half_d;
      edge_q <= edge_d;
      cnt_q  <= cnt_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
      out_q  <= out_d;
      done_q <= done_d;
      sck_q  <= sck_d;
    end
  end

  assign sck_out     = sck_q;
  assign mosi_out    = tx_q[DATA_W-1];
  assign miso_out    = tx_q[DATA_W-1];
  assign sh.rx_done  = done_q;
  assign sh.rx_data  = out_q;
  assign sh.busy     = sh.master ? run_q : sh.selected;
  assign sh.mid_byte = sh.master ? run_q : (edge_q != HALF_ZERO);
  assign sh.sck_edge = slave_edge;

endmodule // spi_shifter

// ---- hdl/spi_cfg_status.sv ----
// spi port: configuration, status flags, data buffers and interrupts
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module spi_cfg_status
#(
  parameter spi_cfg_pkg::byte_t HALF_DIV_DEFAULT = spi_cfg_pkg::HALF_DIV_RST
)
(
  input  logic               clk,
  input  logic               nrst,
  input  spi_cfg_pkg::addr_t reg_addr,
  input  spi_cfg_pkg::byte_t reg_wdata,
  input  logic               reg_wr,
  input  logic               reg_rd,
  output spi_cfg_pkg::byte_t reg_rdata,
  output logic               irq,
  input  logic               sck_in,
  output logic               sck_out,
  output logic               sck_oe_n,
  input  logic               mosi_in,
  output logic               mosi_out,
  output logic               mosi_oe_n,
  input  logic               miso_in,
  output logic               miso_out,
  output logic               miso_oe_n,
  input  logic               slave_select_pin_n
);
  import spi_cfg_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (HALF_DIV_DEFAULT < HALF_DIV_MIN)
  begin : g_div_check
    $error("half period default below the least the engine can serve");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  shift_if sh ();

  logic  master_enable_q;
  logic  master_enable_d;
  logic  clock_edge_phase_q;
  logic  clock_edge_phase_d;
  logic  clock_idle_polarity_q;
  logic  clock_idle_polarity_d;
  byte_t half_div_q;
  byte_t half_div_d;
  byte_t tx_buf_q;
  byte_t tx_buf_d;
  logic  tx_full_q;
  logic  tx_full_d;
  byte_t rx_buf_q;
  byte_t rx_buf_d;
  logic  rx_full_q;
  logic  rx_full_d;
  logic  shifter_empty_flag_q;
  logic  shifter_empty_flag_d;
  irq_t  irq_stat_q;
  irq_t  irq_stat_d;
  irq_t  irq_mask_q;
  irq_t  irq_mask_d;
  logic  irq_q;
  logic  irq_d;
  byte_t rdata_q;
  byte_t rdata_d;
  logic  sel_prev_q;
  logic  sel_prev_d;

  logic  raw_select_pin_level;
  logic  selected_as_slave_flag;
  logic  receive_buffer_empty_flag;
  logic  transfer_busy_flag;
  logic  wr_cfg;
  logic  wr_data;
  logic  wr_stat;
  logic  wr_mask;
  logic  wr_div;
  logic  rd_data;
  logic  load;
  logic  rx_take;
  irq_t  events;
  irq_t  clear_bits;
  byte_t cfg_view;

  // ****************************************************************
  // select pin and shift engine
  // ****************************************************************
  select_filter u_select
  (
    .clk       (clk),
    .nrst      (nrst),
    .pin_n     (slave_select_pin_n),
    .raw_level (raw_select_pin_level),
    .selected  (selected_as_slave_flag)
  );

  spi_shifter u_shifter
  (
    .clk      (clk),
    .nrst     (nrst),
    .sh       (sh.eng),
    .sck_in   (sck_in),
    .mosi_in  (mosi_in),
    .miso_in  (miso_in),
    .sck_out  (sck_out),
    .mosi_out (mosi_out),
    .miso_out (miso_out)
  );

  assign sh.master   = master_enable_q;
  assign sh.cpol     = clock_idle_polarity_q;
  assign sh.cpha     = clock_edge_phase_q;
  assign sh.half_div = half_div_q;
  assign sh.selected = selected_as_slave_flag;
  assign sh.tx_data  = tx_buf_q;
  assign sh.load     = load;

  assign transfer_busy_flag = sh.busy;

  // ****************************************************************
  // decode and buffer handshakes
  // ****************************************************************
  always_comb
  begin
    wr_cfg  = reg_wr && (reg_addr == CFG_ADDR);
    wr_data = reg_wr && (reg_addr == DATA_ADDR);
    wr_stat = reg_wr && (reg_addr == STAT_ADDR);
    wr_mask = reg_wr && (reg_addr == MASK_ADDR);
    wr_div  = reg_wr && (reg_addr == DIV_ADDR);
    rd_data = reg_rd && (reg_addr == DATA_ADDR);
    // master starts on a waiting byte; slave takes it between bytes
    if (master_enable_q)
    begin
      load = tx_full_q && !sh.busy;
    end
    else
    begin
      load = tx_full_q && !sh.mid_byte;
    end
    // a read in the same cycle frees the buffer for the new byte
    rx_take = sh.rx_done && (!rx_full_q || rd_data);
  end

  // ****************************************************************
  // configuration
  // ****************************************************************
  always_comb
  begin
    master_enable_d       = master_enable_q;
    clock_edge_phase_d    = clock_edge_phase_q;
    clock_idle_polarity_d = clock_idle_polarity_q;
    half_div_d            = half_div_q;
    // mode changes mid transfer would tear the byte, so they are dropped
    if (wr_cfg && !transfer_busy_flag)
    begin
      master_enable_d       = reg_wdata[CFG_MASTER_BIT];
      clock_edge_phase_d    = reg_wdata[CFG_PHASE_BIT];
      clock_idle_polarity_d = reg_wdata[CFG_POL_BIT];
    end
    if (wr_div && !transfer_busy_flag)
    begin
      half_div_d = (reg_wdata < HALF_DIV_MIN) ? HALF_DIV_MIN : reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      master_enable_q       <= CFG_RST[CFG_MASTER_BIT];
      clock_edge_phase_q    <= CFG_RST[CFG_PHASE_BIT];
      clock_idle_polarity_q <= CFG_RST[CFG_POL_BIT];
      half_div_q            <= HALF_DIV_DEFAULT;
    end
    else
    begin
      master_enable_q       <= master_enable_d;
      clock_edge_phase_q    <= clock_edge_phase_d;
      clock_idle_polarity_q <= clock_idle_polarity_d;
      half_div_q            <= half_div_d;
    end
  end

  // ****************************************************************
  // data buffers and status flags
  // ****************************************************************
  always_comb
  begin
    tx_buf_d  = tx_buf_q;
    tx_full_d = tx_full_q;
    rx_buf_d  = rx_buf_q;
    rx_full_d = rx_full_q;
    // a write while full is dropped and reported as a collision, unless the buffer loads in the same cycle
    if (wr_data && (!tx_full_q || load))
    begin
      tx_buf_d  = reg_wdata;
      tx_full_d = 1'b1;
    end
    else if (load)
    begin
      tx_full_d = 1'b0;
    end
    if (rx_take)
    begin
      rx_buf_d  = sh.rx_data;
      rx_full_d = 1'b1;
    end
    else if (rd_data)
    begin
      rx_full_d = 1'b0;
    end
    if (master_enable_q)
    begin
      shifter_empty_flag_d = 1'b1;
    end
    else if (load || sh.sck_edge)
    begin
      shifter_empty_flag_d = 1'b0;
    end
    else if (!sh.mid_byte && !tx_full_q && !sh.rx_done)
    begin
      shifter_empty_flag_d = 1'b1;
    end
    else
    begin
      shifter_empty_flag_d = shifter_empty_flag_q;
    end
  end

  assign receive_buffer_empty_flag = master_enable_q ? 1'b1 : !rx_full_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_buf_q             <= BYTE_ZERO;
      tx_full_q            <= 1'b0;
      rx_buf_q             <= BYTE_ZERO;
      rx_full_q            <= 1'b0;
      shifter_empty_flag_q <= CFG_RST[CFG_SHIFTER_EMPTY_FLAG_BIT];
    end
    else
    begin
      tx_buf_q             <= tx_buf_d;
      tx_full_q            <= tx_full_d;
      rx_buf_q             <= rx_buf_d;
      rx_full_q            <= rx_full_d;
      shifter_empty_flag_q <= shifter_empty_flag_d;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  always_comb
  begin
    events                  = IRQ_ZERO;
    events[IRQ_DONE_BIT]    = sh.rx_done;
    events[IRQ_OVR_BIT]     = sh.rx_done && !rx_take;
    events[IRQ_COLL_BIT]    = wr_data && tx_full_q && !load;
    events[IRQ_SEL_BIT]     = selected_as_slave_flag && !sel_prev_q;
    clear_bits              = wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_ZERO;
    // an event in the clearing cycle survives
    irq_stat_d              = (irq_stat_q & ~clear_bits) | events;
    irq_mask_d              = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_q;
    irq_d                   = |(irq_stat_d & irq_mask_d);
    sel_prev_d              = selected_as_slave_flag;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_q <= IRQ_ZERO;
      irq_mask_q <= IRQ_ZERO;
      irq_q      <= 1'b0;
      sel_prev_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
      sel_prev_q <= sel_prev_d;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_comb
  begin
    cfg_view                 = BYTE_ZERO;
    cfg_view[CFG_BUSY_BIT]   = transfer_busy_flag;
    cfg_view[CFG_MASTER_BIT] = master_enable_q;
    cfg_view[CFG_PHASE_BIT]  = clock_edge_phase_q;
    cfg_view[CFG_POL_BIT]    = clock_idle_polarity_q;
    cfg_view[CFG_SEL_BIT]    = selected_as_slave_flag;
    cfg_view[CFG_RAW_BIT]    = raw_select_pin_level;
    cfg_view[CFG_SHIFTER_EMPTY_FLAG_BIT]   = shifter_empty_flag_q;
    cfg_view[CFG_RECEIVE_BUFFER_EMPTY_FLAG_BIT]  = receive_buffer_empty_flag;
    rdata_d                  = BYTE_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        CFG_ADDR:  rdata_d = cfg_view;
        DATA_ADDR: rdata_d = rx_buf_q;
        STAT_ADDR: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
        MASK_ADDR: rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
        DIV_ADDR:  rdata_d = half_div_q;
        default:   rdata_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= BYTE_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = rdata_q;
  assign irq       = irq_q;
  // master drives clock and data out; a selected slave drives its reply
  assign sck_oe_n  = !master_enable_q;
  assign mosi_oe_n = !master_enable_q;
  assign miso_oe_n = !(!master_enable_q && selected_as_slave_flag);

endmodule // spi_cfg_status

// ---- testbench/spi_cfg_props.sv ----
// assertion checker for the spi configuration and status port
`timescale 1ns/1ps
module spi_cfg_props
#(
  parameter spi_cfg_pkg::byte_t HALF_DIV_DEFAULT = spi_cfg_pkg::HALF_DIV_RST
)
(
  input logic               clk,
  input logic               nrst,
  input logic               reg_wr,
  input logic               reg_rd,
  input spi_cfg_pkg::byte_t reg_rdata,
  input logic               irq,
  input logic               sck_out,
  input logic               sck_oe_n,
  input logic               mosi_oe_n,
  input logic               miso_oe_n,
  input logic               slave_select_pin_n
);
  import spi_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // clock half-period counter
  // ****************************************************************
  byte_t same_q, same_d;
  logic  sck_p_q;
  always_comb
  begin
    same_d = (sck_out != sck_p_q) ? BYTE_ZERO : ((same_q == 8'hff) ? same_q : same_q + CNT_ONE);
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      same_q  <= BYTE_ZERO;
      sck_p_q <= 1'b0;
    end
    else
    begin
      same_q  <= same_d;
      sck_p_q <= sck_out;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  // one-cycle low pulse after a long idle: a filter must swallow it
  sequence s_glitch;
    slave_select_pin_n[*8] ##1 !slave_select_pin_n ##1 slave_select_pin_n;
  endsequence
  sequence s_held_low;
    $fell(slave_select_pin_n) ##1 !slave_select_pin_n[*7];
  endsequence
  sequence s_held_high;
    $rose(slave_select_pin_n) ##1 slave_select_pin_n[*7];
  endsequence
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == BYTE_ZERO)
    else $error("read data not zero outside read cycle");
  a_miso_slave_only: assert property (!miso_oe_n |-> mosi_oe_n && sck_oe_n)
    else $error("miso driven in master mode");
  a_master_pins: assert property (mosi_oe_n == sck_oe_n)
    else $error("clock and mosi drive disagree");
  a_sel_glitch: assert property (s_glitch |-> miso_oe_n[*6])
    else $error("select glitch reached the port");
  a_sel_on: assert property (s_held_low |-> !miso_oe_n || !mosi_oe_n)
    else $error("held select not seen");
  a_sel_off: assert property (s_held_high |-> miso_oe_n)
    else $error("released select still seen");
  a_sck_half: assert property ($changed(sck_out) && !sck_oe_n && $past(!sck_oe_n)
    |-> same_q >= HALF_DIV_DEFAULT - CNT_ONE)
    else $error("serial clock half period too short");
  a_irq_cause: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without a write");
endmodule // spi_cfg_props
bind spi_cfg_status spi_cfg_props #(.HALF_DIV_DEFAULT(HALF_DIV_DEFAULT)) u_props (.clk, .nrst, .reg_wr,
  .reg_rd, .reg_rdata, .irq, .sck_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n, .slave_select_pin_n);

// ---- testbench/spi_peer.sv ----
// behavioural spi peer: slave for master runs, master for slave runs
`timescale 1ns/1ps
module spi_peer
(
  input  logic               clk,
  input  logic               sck,
  input  logic               mosi,
  input  logic               miso,
  output logic               p_sck,
  output logic               p_mosi,
  output logic               p_miso,
  output logic               p_ss_n,
  output spi_cfg_pkg::byte_t rx_byte
);
  import spi_cfg_pkg::*;
  byte_t tx_q;
  initial
  begin
    p_sck   = 1'b0;
    p_mosi  = 1'b0;
    p_ss_n  = 1'b1;
    tx_q    = 8'h3c;
    rx_byte = BYTE_ZERO;
  end
  assign p_miso = tx_q[7];
  // with select low the peer is master and records the port's reply
  always @(posedge sck) rx_byte <= {rx_byte[6:0], p_ss_n ? mosi : miso};
  // inverse shifted in, so a stale bit never passes for data
  always @(negedge sck) tx_q <= {tx_q[6:0], ~tx_q[7]};
  task automatic send(input byte_t b);
    #3 p_ss_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--)
    begin
      p_mosi = b[i];
      #40 p_sck = 1'b1;
      #40 p_sck = 1'b0;
    end
    #200 p_ss_n = 1'b1;
    p_mosi = ~p_mosi;
  endtask
  // leading-edge phase shifts once before the first sample
  task automatic preload(input byte_t b, input logic lead);
    tx_q = lead ? {~b[0], b[7:1]} : b;
  endtask
  task automatic glitch();
    @(posedge clk);
    #1 p_ss_n = 1'b0;
    @(posedge clk);
    #1 p_ss_n = 1'b1;
  endtask
endmodule // spi_peer

// ---- testbench/tb_spi_cfg_status.sv ----
// self-checking bench for the spi configuration and status port
`timescale 1ns/1ps
module tb_spi_cfg_status;
  import spi_cfg_pkg::*;
  logic  clk, nrst, reg_wr, reg_rd, irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic  p_sck, p_mosi, p_miso, p_ss_n, sck_w, mosi_w, miso_w;
  addr_t reg_addr;
  byte_t reg_wdata, reg_rdata, d, peer_rx;
  int    mismatches, checked, n;
  assign sck_w  = sck_oe_n ? p_sck : sck_out;
  assign mosi_w = mosi_oe_n ? p_mosi : mosi_out;
  assign miso_w = miso_oe_n ? p_miso : miso_out;
  always #5 clk = ~clk;
  spi_cfg_status u_dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .sck_in(sck_w), .sck_out, .sck_oe_n, .mosi_in(mosi_w), .mosi_out, .mosi_oe_n,
    .miso_in(miso_w), .miso_out, .miso_oe_n, .slave_select_pin_n(p_ss_n));
  spi_peer u_peer (.clk, .sck(sck_w), .mosi(mosi_w), .miso(miso_w), .p_sck, .p_mosi, .p_miso, .p_ss_n,
    .rx_byte(peer_rx));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input byte_t got, input byte_t exp);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask
  task automatic wr(input addr_t a, input byte_t v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input addr_t a, output byte_t v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic time_out(input string name);
    $display("[ERR] %s expected end seen timeout", name);
    mismatches++;
    give_verdict();
  endtask
  task automatic wait_idle();
    n = 0;
    d = 8'h80;
    while (d[CFG_BUSY_BIT] !== 1'b0 && n < 200)
    begin
      rd(CFG_ADDR, d);
      n++;
    end
    if (d[CFG_BUSY_BIT] !== 1'b0)
      time_out("busy");
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial
  begin
    {clk, nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(CFG_ADDR, d);
    chk("cfg reset", d, CFG_RST);
    settle(8);
    u_peer.glitch();
    settle(6);
    rd(CFG_ADDR, d);
    chk("sel glitch", d & 8'h08, BYTE_ZERO);
    rd(STAT_ADDR, d);
    chk("sel sticky", d, BYTE_ZERO);
    wr(CFG_ADDR, 8'h50);
    settle(4);
    chk("idle high", {7'h00, sck_out}, 8'h01);
    wr(CFG_ADDR, 8'h40);
    settle(4);
    chk("idle low", {7'h00, sck_out}, BYTE_ZERO);
    u_peer.preload(8'h3c, 1'b0);
    wr(MASK_ADDR, BYTE_ZERO);
    wr(DATA_ADDR, 8'ha5);
    rd(CFG_ADDR, d);
    chk("busy", d & 8'h80, 8'h80);
    wait_idle();
    chk("master flags", d & 8'hc3, 8'h43);
    chk("irq masked", {7'h00, irq}, BYTE_ZERO);
    rd(DATA_ADDR, d);
    chk("master rx", d, 8'h3c);
    chk("peer rx", peer_rx, 8'ha5);
    wr(CFG_ADDR, 8'h70);
    settle(4);
    chk("idle high 3", {7'h00, sck_out}, 8'h01);
    u_peer.preload(8'hc3, 1'b1);
    wr(DATA_ADDR, 8'h96);
    wait_idle();
    rd(DATA_ADDR, d);
    chk("phase 1 rx", d, 8'hc3);
    chk("phase 1 peer", peer_rx, 8'h96);
    rd(STAT_ADDR, d);
    chk("done flag", d, 8'h01);
    wr(MASK_ADDR, 8'h01);
    settle(2);
    chk("irq on", {7'h00, irq}, 8'h01);
    wr(STAT_ADDR, 8'h01);
    settle(2);
    chk("irq off", {7'h00, irq}, BYTE_ZERO);
    wr(3'h7, 8'hff);
    rd(3'h7, d);
    chk("unmapped", d, BYTE_ZERO);
    wr(CFG_ADDR, BYTE_ZERO);
    wr(DATA_ADDR, 8'h69);
    fork
      u_peer.send(8'h5a);
    join_none
    settle(10);
    rd(CFG_ADDR, d);
    chk("selected", d & 8'h8c, 8'h88);
    settle(20);
    rd(CFG_ADDR, d);
    chk("mid byte", d & 8'h02, BYTE_ZERO);
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      settle(1);
      n++;
    end
    if (irq !== 1'b1)
      time_out("irq");
    rd(CFG_ADDR, d);
    chk("rx pending", d & 8'h01, BYTE_ZERO);
    rd(DATA_ADDR, d);
    chk("slave rx", d, 8'h5a);
    wait fork;
    chk("slave tx", peer_rx, 8'h69);
    settle(8);
    rd(CFG_ADDR, d);
    chk("idle cfg", d, CFG_RST);
    give_verdict();
  end
endmodule // tb_spi_cfg_status
